// >>> hdl/spa_host.sv
// host controller: identification reads, protection status and group protect/unprotect
`include "spa_defines.svh"
module spa_host (
	input  wire logic                       clock,
	input  wire logic                       rst_b,
	input  wire logic                       cmd_valid,
	output logic                            cmd_ready,
	input  wire spa_pkg::spa_op_t           cmd_op,
	input  wire logic [`SPA_SECT_W-1:0]     cmd_sector_index,
	input  wire logic                       cmd_in_system,
	output logic                            rsp_valid,
	output logic [15:0]                     rsp_data,
	output logic                            rsp_flag,
	output logic [`SPA_ADDR_W-1:0]          flash_addr,
	output logic                            flash_ce_b,
	output logic                            flash_oe_b,
	output logic                            flash_we_b,
	output logic                            elevated_id_voltage,
	output logic                            reset_hv_en,
	input  wire logic [15:0]                dq_in,
	output logic [15:0]                     dq_out,
	output logic                            dq_oe
);
	import spa_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	spa_state_t              st_q,    st_d;
	spa_op_t                 op_q,    op_d;
	logic [`SPA_SECT_W-1:0]  sect_q,  sect_d;
	logic                    insys_q, insys_d;
	logic [11:0]             cnt_q,   cnt_d;
	logic [`SPA_ADDR_W-1:0]  addr_q,  addr_d;
	logic                    ce_b_q,  ce_b_d;
	logic                    oe_b_q,  oe_b_d;
	logic                    we_b_q,  we_b_d;
	logic                    hv9_q,   hv9_d;
	logic                    hvr_q,   hvr_d;
	logic [15:0]             dqo_q,   dqo_d;
	logic                    dqoe_q,  dqoe_d;
	logic [15:0]             data_q,  data_d;
	logic                    flag_q,  flag_d;
	logic                    rv_q,    rv_d;
	logic [15:0]             dq_s2;
	logic [15:0]             dq_s3;

	spa_sync #(.WIDTH(16)) u_dq_sync (
		.clock  (clock),
		.rst_b  (rst_b),
		.pin    (dq_in),
		.stage2 (dq_s2),
		.stage3 (dq_s3)
	);

	// other address lines are don't-care to the device; drive them low
	function automatic logic [`SPA_ADDR_W-1:0] id_addr(input logic [`SPA_SECT_W-1:0] s,
		input logic a6, input logic [1:0] sel);
		logic [`SPA_ADDR_W-1:0] a;
		a = '0;
		a[`SPA_ADDR_W-1:`SPA_SECT_LSB] = s;
		a[`SPA_A6_BIT] = a6;
		a[1:0] = sel;
		return a;
	endfunction

	function automatic logic [1:0] op_sel(input spa_op_t o);
		logic [1:0] r;
		r = `SPA_SEL_PROT;
		unique case (o)
			SPA_OP_MFR:    r = `SPA_SEL_MFR;
			SPA_OP_DEV:    r = `SPA_SEL_DEV;
			SPA_OP_REGION: r = `SPA_SEL_REGION;
			default:       r = `SPA_SEL_PROT;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		st_d    = st_q;
		op_d    = op_q;
		sect_d  = sect_q;
		insys_d = insys_q;
		cnt_d   = cnt_q;
		addr_d  = addr_q;
		ce_b_d  = ce_b_q;
		oe_b_d  = oe_b_q;
		we_b_d  = we_b_q;
		hv9_d   = hv9_q;
		hvr_d   = hvr_q;
		dqo_d   = dqo_q;
		dqoe_d  = dqoe_q;
		data_d  = data_q;
		flag_d  = flag_q;
		rv_d    = 1'b0;
		unique case (st_q)
			SPA_ST_IDLE: begin
				if (cmd_valid) begin
					op_d    = cmd_op;
					insys_d = cmd_in_system;
					cnt_d   = '0;
					ce_b_d  = 1'b0;
					unique case (cmd_op)
						SPA_OP_PROTECT: begin
							// group granularity: low two sector bits dropped
							sect_d = {cmd_sector_index[`SPA_SECT_W-1:2], 2'b00};
							addr_d = id_addr({cmd_sector_index[`SPA_SECT_W-1:2], 2'b00},
								1'b0, `SPA_SEL_PROT);
							hvr_d  = 1'b1;
							we_b_d = 1'b0;
							st_d   = SPA_ST_PULSE;
						end
						SPA_OP_UNPROT_ALL: begin
							// scan starts at group 0, always via elevated A9
							sect_d  = '0;
							insys_d = 1'b0;
							addr_d  = id_addr('0, 1'b0, `SPA_SEL_PROT);
							hv9_d   = 1'b1;
							oe_b_d  = 1'b0;
							st_d    = SPA_ST_READ;
						end
						default: begin
							sect_d = cmd_sector_index;
							if (cmd_in_system) begin
								// command write first, no elevated voltage
								addr_d = `SPA_CMD_ADDR;
								dqo_d  = `SPA_CMD_DATA;
								dqoe_d = 1'b1;
								we_b_d = 1'b0;
								st_d   = SPA_ST_CMD_WR;
							end else begin
								addr_d = id_addr(cmd_sector_index, 1'b0, op_sel(cmd_op));
								hv9_d  = 1'b1;
								oe_b_d = 1'b0;
								st_d   = SPA_ST_READ;
							end
						end
					endcase
				end
			end
			SPA_ST_CMD_WR: begin
				cnt_d = cnt_q + 12'h001;
				if (cnt_q == `SPA_WP_CYC - 12'h001) begin
					we_b_d = 1'b1;
					dqoe_d = 1'b0;
					cnt_d  = '0;
					addr_d = id_addr(sect_q, 1'b0, op_sel(op_q));
					oe_b_d = 1'b0;
					st_d   = SPA_ST_READ;
				end
			end
			SPA_ST_READ: begin
				// data is taken only after access time and two agreeing samples
				if (cnt_q < `SPA_ACC_CYC) begin
					cnt_d = cnt_q + 12'h001;
				end else if (dq_s2 == dq_s3) begin
					cnt_d  = '0;
					oe_b_d = 1'b1;
					data_d = dq_s3;
					if (op_q == SPA_OP_REGION) begin
						flag_d = dq_s3[`SPA_LOCK_BIT];
					end else begin
						// upper byte may be anything on status reads
						flag_d = (dq_s3[7:0] == 8'h01);
					end
					if (op_q == SPA_OP_UNPROT_ALL) begin
						if (dq_s3[`SPA_PROT_BIT] == 1'b0) begin
							// unprotected group: protect before any unprotect write
							hv9_d  = 1'b0;
							hvr_d  = 1'b1;
							we_b_d = 1'b0;
							st_d   = SPA_ST_PULSE;
						end else if (sect_q[`SPA_SECT_W-1:2] == `SPA_GRP_LAST) begin
							hv9_d  = 1'b0;
							hvr_d  = 1'b1;
							we_b_d = 1'b0;
							addr_d = id_addr('0, 1'b1, `SPA_SEL_PROT);
							st_d   = SPA_ST_UNPROT;
						end else begin
							sect_d = sect_q + 7'h04;
							addr_d = id_addr(sect_q + 7'h04, 1'b0, `SPA_SEL_PROT);
							oe_b_d = 1'b0;
						end
					end else begin
						hv9_d  = 1'b0;
						ce_b_d = 1'b1;
						st_d   = SPA_ST_DONE;
					end
				end
			end
			SPA_ST_PULSE: begin
				cnt_d = cnt_q + 12'h001;
				if (cnt_q == `SPA_PULSE_CYC - 12'h001) begin
					cnt_d  = '0;
					we_b_d = 1'b1;
					hvr_d  = 1'b0;
					if (op_q == SPA_OP_UNPROT_ALL) begin
						// last group is read back, not chained into the unprotect write:
						// its protect write must be closed by a rising write strobe first
						if (sect_q[`SPA_SECT_W-1:2] != `SPA_GRP_LAST) begin
							sect_d = sect_q + 7'h04;
						end
						addr_d = id_addr(sect_d, 1'b0, `SPA_SEL_PROT);
						hv9_d  = 1'b1;
						oe_b_d = 1'b0;
						st_d   = SPA_ST_READ;
					end else begin
						ce_b_d = 1'b1;
						flag_d = 1'b1;
						st_d   = SPA_ST_DONE;
					end
				end
			end
			SPA_ST_UNPROT: begin
				// single unprotect write clears every group at once
				cnt_d = cnt_q + 12'h001;
				if (cnt_q == `SPA_UNPROT_CYC - 12'h001) begin
					cnt_d  = '0;
					we_b_d = 1'b1;
					hvr_d  = 1'b0;
					ce_b_d = 1'b1;
					flag_d = 1'b0;
					st_d   = SPA_ST_DONE;
				end
			end
			SPA_ST_DONE: begin
				rv_d   = 1'b1;
				addr_d = '0;
				st_d   = SPA_ST_IDLE;
			end
			default: begin
				st_d = SPA_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_q    <= SPA_ST_IDLE;
			op_q    <= SPA_OP_MFR;
			sect_q  <= '0;
			insys_q <= 1'b0;
			cnt_q   <= '0;
			addr_q  <= '0;
			ce_b_q  <= 1'b1;
			oe_b_q  <= 1'b1;
			we_b_q  <= 1'b1;
			hv9_q   <= 1'b0;
			hvr_q   <= 1'b0;
			dqo_q   <= '0;
			dqoe_q  <= 1'b0;
			data_q  <= '0;
			flag_q  <= 1'b0;
			rv_q    <= 1'b0;
		end else begin
			st_q    <= st_d;
			op_q    <= op_d;
			sect_q  <= sect_d;
			insys_q <= insys_d;
			cnt_q   <= cnt_d;
			addr_q  <= addr_d;
			ce_b_q  <= ce_b_d;
			oe_b_q  <= oe_b_d;
			we_b_q  <= we_b_d;
			hv9_q   <= hv9_d;
			hvr_q   <= hvr_d;
			dqo_q   <= dqo_d;
			dqoe_q  <= dqoe_d;
			data_q  <= data_d;
			flag_q  <= flag_d;
			rv_q    <= rv_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign cmd_ready           = (st_q == SPA_ST_IDLE);
	assign rsp_valid           = rv_q;
	assign rsp_data            = data_q;
	assign rsp_flag            = flag_q;
	assign flash_addr          = addr_q;
	assign flash_ce_b          = ce_b_q;
	assign flash_oe_b          = oe_b_q;
	assign flash_we_b          = we_b_q;
	assign elevated_id_voltage = hv9_q;
	assign reset_hv_en         = hvr_q;
	assign dq_out              = dqo_q;
	assign dq_oe               = dqoe_q;
endmodule

// >>> hdl/spa_defines.svh
// timing counts, address fields and code positions for the sector protect / autoselect host
//
// Functional notes
// - host holds the elevated identification voltage on A9 while reading codes.
// - chip select, output enable low, write strobe high, A6 low; A1/A0 pick code.
// - codes also readable in-system after a command write, without elevated voltage.
// - protect and unprotect need elevated voltage only on the reset pin.
// - every unprotected group is protected before the first unprotect write.
`ifndef SPA_DEFINES_SVH
`define SPA_DEFINES_SVH

`define SPA_CLK_NS        4
`define SPA_ADDR_W        22
`define SPA_SECT_W        7
`define SPA_GRP_W         5
`define SPA_SECT_LSB      15
`define SPA_GRP_LAST      5'h1f
`define SPA_A6_BIT        6
// status reads: low byte only
`define SPA_PROT_BIT      0
`define SPA_LOCK_BIT      7
// a1/a0 selectors
`define SPA_SEL_MFR       2'h0
`define SPA_SEL_DEV       2'h1
`define SPA_SEL_PROT      2'h2
`define SPA_SEL_REGION    2'h3
// in-system autoselect command write
`define SPA_CMD_ADDR      22'h000000
`define SPA_CMD_DATA      16'h0000
// times in ns, counts in clock cycles (least times, rounded up)
`define SPA_T_ACC_NS      100
`define SPA_T_WP_NS       50
`define SPA_T_PULSE_NS    1000
`define SPA_T_UNPROT_NS   2000
`define SPA_CYC(ns)       (((ns) + `SPA_CLK_NS - 1) / `SPA_CLK_NS)
`define SPA_ACC_CYC       12'(`SPA_CYC(`SPA_T_ACC_NS))
`define SPA_WP_CYC        12'(`SPA_CYC(`SPA_T_WP_NS))
`define SPA_PULSE_CYC     12'(`SPA_CYC(`SPA_T_PULSE_NS))
`define SPA_UNPROT_CYC    12'(`SPA_CYC(`SPA_T_UNPROT_NS))

`endif

// >>> hdl/spa_pkg.sv
// types shared by the sector protect / autoselect host
package spa_pkg;

	typedef enum logic [2:0] {
		SPA_OP_MFR,
		SPA_OP_DEV,
		SPA_OP_PROT,
		SPA_OP_REGION,
		SPA_OP_PROTECT,
		SPA_OP_UNPROT_ALL
	} spa_op_t;

	typedef enum logic [2:0] {
		SPA_ST_IDLE,
		SPA_ST_CMD_WR,
		SPA_ST_READ,
		SPA_ST_PULSE,
		SPA_ST_UNPROT,
		SPA_ST_DONE
	} spa_state_t;

endpackage

// >>> hdl/spa_sync.sv
// three-stage synchroniser for pin inputs
module spa_sync #(
	parameter int WIDTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] stage2,
	output logic      [WIDTH-1:0] stage3
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign stage2 = s2_q;
	assign stage3 = s3_q;
endmodule

// >>> dv/spa_host_props.sv
// port assertions for the sector protect / autoselect host
`include "spa_defines.svh"
module spa_host_chk (
	input wire logic                   clock,
	input wire logic                   rst_b,
	input wire logic                   cmd_valid,
	input wire logic                   cmd_ready,
	input wire spa_pkg::spa_op_t       cmd_op,
	input wire logic [`SPA_SECT_W-1:0] cmd_sector_index,
	input wire logic                   cmd_in_system,
	input wire logic                   rsp_valid,
	input wire logic [`SPA_ADDR_W-1:0] flash_addr,
	input wire logic                   flash_ce_b,
	input wire logic                   flash_oe_b,
	input wire logic                   flash_we_b,
	input wire logic                   elevated_id_voltage,
	input wire logic                   reset_hv_en
);
	timeunit 1ns;
	timeprecision 1ps;
	import spa_pkg::*;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [11:0] hv_cnt_q;
	logic [11:0] hv_cnt_d;
	always_comb hv_cnt_d = reset_hv_en ? hv_cnt_q + 12'h001 : 12'h000;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) hv_cnt_q <= 12'h000;
		else hv_cnt_q <= hv_cnt_d;
	end
	sequence s_taken;
		cmd_valid && cmd_ready;
	endsequence
	sequence s_hv_read;
		s_taken ##0 !cmd_in_system && cmd_op inside {SPA_OP_MFR, SPA_OP_DEV, SPA_OP_PROT, SPA_OP_REGION};
	endsequence
	a_hv_read_pins: assert property (elevated_id_voltage |-> !flash_ce_b && !flash_oe_b
		&& flash_we_b && !flash_addr[`SPA_A6_BIT]) else $error("id read pins wrong");
	a_ignored_lines_low: assert property (elevated_id_voltage |-> (flash_addr & 22'h007dbc) == 22'h0)
		else $error("ignored address lines not low");
	a_sector_on_addr: assert property (s_hv_read ##0 cmd_op == SPA_OP_PROT |=>
		flash_addr[21:15] == $past(cmd_sector_index) && flash_addr[1:0] == `SPA_SEL_PROT)
		else $error("sector index not on upper lines");
	a_read_answer_time: assert property (s_hv_read |-> ##[25:300] rsp_valid)
		else $error("read answer missing");
	a_busy_after_take: assert property (s_taken |=> (!cmd_ready && !rsp_valid)[*8])
		else $error("ready or answer too early");
	a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
		else $error("answer not a single pulse");
	a_hv_reset_only: assert property (reset_hv_en |-> !elevated_id_voltage && flash_oe_b)
		else $error("elevated voltage on wrong pin");
	a_protect_write: assert property ($rose(reset_hv_en) |-> !flash_we_b && !flash_ce_b
		&& flash_addr[1:0] == `SPA_SEL_PROT) else $error("protect write cycle wrong");
	a_pulse_long: assert property ($fell(reset_hv_en) |-> hv_cnt_q >= `SPA_PULSE_CYC)
		else $error("protect pulse too short");
endmodule
bind spa_host spa_host_chk spa_host_chk_i (.clock, .rst_b, .cmd_valid, .cmd_ready, .cmd_op,
	.cmd_sector_index, .cmd_in_system, .rsp_valid, .flash_addr, .flash_ce_b, .flash_oe_b,
	.flash_we_b, .elevated_id_voltage, .reset_hv_en);

// >>> dv/spa_flash_model.sv
// behavioural flash: identification codes and group protection state
`include "spa_defines.svh"
module spa_flash_model #(
	parameter logic [15:0] MFR_CODE = 16'h00a5, // arbitrary value
	parameter logic [15:0] DEV_CODE = 16'h5a3c  // arbitrary value
) (
	input wire logic                   clock,
	input wire logic [`SPA_ADDR_W-1:0] flash_addr,
	input wire logic                   flash_ce_b,
	input wire logic                   flash_oe_b,
	input wire logic                   flash_we_b,
	input wire logic                   elevated_id_voltage,
	input wire logic                   reset_hv_en,
	input wire logic [15:0]            dq_out,
	input wire logic                   dq_oe,
	output logic [15:0]                dq_in,
	output logic                       order_fault
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] prot_q = 32'h0;
	logic        autosel_q = 1'b0;
	logic        pend_q = 1'b0;
	logic        unp_q;
	logic [4:0]  grp_q;
	logic [15:0] last_q = 16'h0;
	logic [15:0] code;
	logic        rd;
	initial order_fault = 1'b0;
	assign rd = !flash_ce_b && !flash_oe_b && (elevated_id_voltage || autosel_q);
	// only a1/a0 and the group lines decode; upper byte of status is junk
	always_comb begin
		case (flash_addr[1:0])
			2'h0: code = MFR_CODE;
			2'h1: code = DEV_CODE;
			2'h2: code = {8'hc3, 7'h00, prot_q[flash_addr[21:17]]};
			default: code = 16'hc398;
		endcase
	end
	// released lines show the inverse of the last value so nothing stale passes
	assign dq_in = dq_oe ? dq_out : rd ? code : ~last_q;
	always @(posedge clock) begin
		last_q <= dq_in;
		if (!flash_ce_b && !flash_we_b) begin
			if (reset_hv_en) begin
				pend_q <= 1'b1;
				unp_q <= flash_addr[6];
				grp_q <= flash_addr[21:17];
			end else if (flash_addr == `SPA_CMD_ADDR && dq_oe && dq_out == `SPA_CMD_DATA) begin
				autosel_q <= 1'b1;
			end
		end else if (pend_q) begin
			pend_q <= 1'b0;
			if (!unp_q) prot_q[grp_q] <= 1'b1;
			else if (&prot_q) prot_q <= 32'h0;
			else order_fault <= 1'b1;
		end
	end
endmodule

// >>> dv/tb_sector_protect_autoselect.sv
// self-checking bench for the sector protect / autoselect host
`include "spa_defines.svh"
module tb_sector_protect_autoselect;
	timeunit 1ns;
	timeprecision 1ps;
	import spa_pkg::*;
	localparam logic [15:0] MFR = 16'h00a5;
	localparam logic [15:0] DEV = 16'h5a3c;
	logic clock, rst_b, cmd_valid, cmd_ready, cmd_in_system, rsp_valid, rsp_flag, dq_oe;
	logic flash_ce_b, flash_oe_b, flash_we_b, elevated_id_voltage, reset_hv_en, order_fault;
	spa_op_t     cmd_op;
	logic [6:0]  cmd_sector_index, t;
	logic [15:0] rsp_data, dq_in, dq_out;
	logic [21:0] flash_addr;
	logic [31:0] prot_sh;
	int          n_errors, comparisons, k;
	spa_host spa_host_i (.clock, .rst_b, .cmd_valid, .cmd_ready, .cmd_op, .cmd_sector_index,
		.cmd_in_system, .rsp_valid, .rsp_data, .rsp_flag, .flash_addr, .flash_ce_b, .flash_oe_b,
		.flash_we_b, .elevated_id_voltage, .reset_hv_en, .dq_in, .dq_out, .dq_oe);
	spa_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) spa_flash_model_i (.clock, .flash_addr,
		.flash_ce_b, .flash_oe_b, .flash_we_b, .elevated_id_voltage, .reset_hv_en, .dq_out,
		.dq_oe, .dq_in, .order_fault);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	function automatic logic [15:0] exp_word(spa_op_t op, logic [6:0] s);
		case (op)
			SPA_OP_MFR: return MFR;
			SPA_OP_DEV: return DEV;
			SPA_OP_PROT: return {15'h0, prot_sh[s[6:2]]};
			default: return 16'h0098;
		endcase
	endfunction
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			n_errors++;
		end
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic run(spa_op_t op, logic [6:0] s, logic ins);
		int i;
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_sector_index <= s;
		cmd_in_system <= ins;
		@(negedge clock);
		for (i = 0; cmd_ready !== 1'b1; i++) begin
			if (i == 100) begin
				n_errors++;
				end_of_test();
			end
			@(negedge clock);
		end
		@(posedge clock);
		cmd_valid <= 1'b0;
		@(negedge clock);
		for (i = 0; rsp_valid !== 1'b1; i++) begin
			if (i == 20000) begin
				n_errors++;
				end_of_test();
			end
			@(negedge clock);
		end
		check("fault", {15'h0, order_fault}, 16'h0);
	endtask
	task automatic rd(spa_op_t op, logic [6:0] s, logic ins);
		logic [15:0] e;
		e = exp_word(op, s);
		run(op, s, ins);
		if (op == SPA_OP_PROT || op == SPA_OP_REGION)
			check("status", {8'h00, rsp_data[7:0]}, e);
		else
			check("code", rsp_data, e);
		check("flag", {15'h0, rsp_flag}, {15'h0, op == SPA_OP_REGION ? e[7] : e[7:0] == 8'h01});
	endtask
	initial begin
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = SPA_OP_MFR;
		cmd_sector_index = 7'h00;
		cmd_in_system = 1'b0;
		n_errors = 0;
		comparisons = 0;
		prot_sh = 32'h0;
		void'($urandom(70));
		repeat (16) @(posedge clock);
		check("ce idle", {15'h0, flash_ce_b}, 16'h0001);
		rst_b <= 1'b1;
		// high-voltage reads first: the in-system command leaves the part in id mode
		for (k = 0; k < 8; k++) rd(spa_op_t'(k % 4), 7'($urandom), 1'(k / 4));
		for (k = 0; k < 3; k++) begin
			t = k == 0 ? 7'($urandom) : k == 1 ? 7'h7f : 7'h00;
			run(SPA_OP_PROTECT, t, 1'b0);
			check("protect flag", {15'h0, rsp_flag}, 16'h0001);
			prot_sh[t[6:2]] = 1'b1;
			rd(SPA_OP_PROT, {t[6:2], 2'($urandom)}, 1'b0);
			rd(SPA_OP_PROT, 7'($urandom), 1'b0);
		end
		// second pass finds every group open, the last one included
		for (k = 0; k < 2; k++) begin
			run(SPA_OP_UNPROT_ALL, 7'h00, 1'b0);
			check("unprotect flag", {15'h0, rsp_flag}, 16'h0000);
		end
		prot_sh = 32'h0;
		rd(SPA_OP_PROT, t, 1'b0);
		rd(SPA_OP_PROT, 7'h7f, 1'b1);
		end_of_test();
	end
endmodule
